// *** rtl/emzo_pkg.sv ***
// Constants for the error mask and zone temperature offset register bank.
// Assumes an 8-bit register port driven by the management interface logic.
// Function
// - Mask bit 0 suppresses regulator hot A events.
// - Mask bit 1 suppresses regulator hot B events.
// - Mask bit 2 suppresses termination sense A events.
// - Mask bit 3 suppresses termination sense B events.
// - Mask bit 4 suppresses channel seven core-voltage events.
// - Mask bit 5 suppresses channel eight core-voltage events.
// - Mask register at EDh, reset 3Fh, 7:6 reserved.
// - Zone 2 offset: signed 6 bits at EFh.
// - Zone 2 offset added when measurement is taken.
// - Corrected temperature used everywhere as true value.
// - Offset range +31 to -32 degrees, 1-degree steps.
// - Zone 1 offset register at EEh, same layout.
package emzo_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] EMZO_MISC_ERROR_MASK_ADDR   = 8'hED;
    localparam logic [7:0] EMZO_ZONE1_TEMP_OFFSET_ADDR = 8'hEE;
    localparam logic [7:0] EMZO_ZONE2_TEMP_OFFSET_ADDR = 8'hEF;

    localparam logic [5:0] EMZO_MISC_ERROR_MASK_RESET  = 6'h3F;
    localparam logic [5:0] EMZO_ZONE_OFFSET_RESET      = 6'h00;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int EMZO_MASK_WIDTH       = 6;
    localparam int EMZO_OFFSET_WIDTH     = 6;
    localparam int EMZO_REGULATOR_HOT_A  = 0;
    localparam int EMZO_REGULATOR_HOT_B  = 1;
    localparam int EMZO_TERM_SENSE_A     = 2;
    localparam int EMZO_TERM_SENSE_B     = 3;
    localparam int EMZO_CORE_VOLT_A      = 4;
    localparam int EMZO_CORE_VOLT_B      = 5;

endpackage

// *** rtl/emzo_offset_if.sv ***
// Carries one zone's raw and corrected temperature sample.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
interface emzo_offset_if #(parameter int TEMP_WIDTH = 8);
    logic                  raw_valid;
    logic [TEMP_WIDTH-1:0] raw_temp;
    logic [5:0]            offset;
    logic                  corr_valid;
    logic [TEMP_WIDTH-1:0] corr_temp;

    modport bank  (output raw_valid, output raw_temp, output offset, input corr_valid, input corr_temp);
    modport adder (input raw_valid, input raw_temp, input offset, output corr_valid, output corr_temp);
endinterface

// *** rtl/emzo_offset_adder.sv ***
// Adds a signed zone offset to each temperature sample as it is taken.
// Assumes raw_valid marks one sample per pulse; output is registered.
`timescale 1ns/1ps
module emzo_offset_adder
    import emzo_pkg::*;
#(
    parameter int TEMP_WIDTH = 8
)(
    input  wire logic    clock,
    input  wire logic    rst,
    emzo_offset_if.adder zone
);

    logic                  valid_reg;
    logic                  valid_next;
    logic [TEMP_WIDTH-1:0] temp_reg;
    logic [TEMP_WIDTH-1:0] temp_next;
    logic [TEMP_WIDTH-1:0] offset_ext;

    always_comb
    begin
        offset_ext = {{(TEMP_WIDTH-EMZO_OFFSET_WIDTH){zone.offset[EMZO_OFFSET_WIDTH-1]}}, zone.offset};
        valid_next = zone.raw_valid;
        temp_next  = temp_reg;
        if (zone.raw_valid)
        begin
            // Two's complement wrap gives -32..+31 in whole degrees.
            temp_next = zone.raw_temp + offset_ext;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            valid_reg <= 1'b0;
            temp_reg  <= '0;
        end
        else
        begin
            valid_reg <= valid_next;
            temp_reg  <= temp_next;
        end
    end

    assign zone.corr_valid = valid_reg;
    assign zone.corr_temp  = temp_reg;

endmodule

// *** rtl/emzo_bank.sv ***
// Miscellaneous error mask and the two zone temperature offset registers.
// Assumes a byte-wide register port from the management interface on the same clock.
`timescale 1ns/1ps
module emzo_bank
    import emzo_pkg::*;
#(
    parameter int TEMP_WIDTH = 8
)(
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic [7:0]            reg_addr,
    input  wire logic                  reg_write,
    input  wire logic [7:0]            reg_wdata,
    output logic      [7:0]            reg_rdata,
    input  wire logic                  regulator_hot_a_input,
    input  wire logic                  regulator_hot_b_input,
    input  wire logic                  term_sense_a_input,
    input  wire logic                  term_sense_b_input,
    input  wire logic                  core_volt_a_event,
    input  wire logic                  core_volt_b_event,
    output logic      [5:0]            error_event,
    input  wire logic                  zone1_raw_valid,
    input  wire logic [TEMP_WIDTH-1:0] zone1_raw_temp,
    input  wire logic                  zone2_raw_valid,
    input  wire logic [TEMP_WIDTH-1:0] zone2_raw_temp,
    output logic                       zone1_temp_valid,
    output logic      [TEMP_WIDTH-1:0] zone1_temp,
    output logic                       zone2_temp_valid,
    output logic      [TEMP_WIDTH-1:0] zone2_temp
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [5:0] misc_error_mask_reg;
    logic [5:0] misc_error_mask_next;
    logic [5:0] zone1_offset_field_reg;
    logic [5:0] zone1_offset_field_next;
    logic [5:0] zone2_offset_field_reg;
    logic [5:0] zone2_offset_field_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    always_comb
    begin
        misc_error_mask_next    = misc_error_mask_reg;
        zone1_offset_field_next = zone1_offset_field_reg;
        zone2_offset_field_next = zone2_offset_field_reg;
        if (reg_write)
        begin
            unique case (reg_addr)
                EMZO_MISC_ERROR_MASK_ADDR:   misc_error_mask_next    = reg_wdata[5:0];
                EMZO_ZONE1_TEMP_OFFSET_ADDR: zone1_offset_field_next = reg_wdata[5:0];
                EMZO_ZONE2_TEMP_OFFSET_ADDR: zone2_offset_field_next = reg_wdata[5:0];
                default:                     ;
            endcase
        end
        // Reserved bits 7:6 read as zero; unmapped addresses read zero.
        unique case (reg_addr)
            EMZO_MISC_ERROR_MASK_ADDR:   rdata_next = {2'h0, misc_error_mask_next};
            EMZO_ZONE1_TEMP_OFFSET_ADDR: rdata_next = {2'h0, zone1_offset_field_next};
            EMZO_ZONE2_TEMP_OFFSET_ADDR: rdata_next = {2'h0, zone2_offset_field_next};
            default:                     rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            misc_error_mask_reg    <= EMZO_MISC_ERROR_MASK_RESET;
            zone1_offset_field_reg <= EMZO_ZONE_OFFSET_RESET;
            zone2_offset_field_reg <= EMZO_ZONE_OFFSET_RESET;
            rdata_reg              <= 8'h00;
        end
        else
        begin
            misc_error_mask_reg    <= misc_error_mask_next;
            zone1_offset_field_reg <= zone1_offset_field_next;
            zone2_offset_field_reg <= zone2_offset_field_next;
            rdata_reg              <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    // ------------------------------------------------------------------
    // Pin synchronisers and error masking
    // ------------------------------------------------------------------
    // The four pin inputs pass three flops; a level is accepted only once
    // the second and third stages agree, so a single glitch is dropped.
    logic [3:0] pin_raw;
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic [3:0] sync3_reg;
    logic [3:0] pin_level_reg;
    logic [3:0] pin_level_next;
    logic [5:0] event_raw;
    logic [5:0] event_reg;
    logic [5:0] event_next;

    assign pin_raw = {term_sense_b_input, term_sense_a_input, regulator_hot_b_input, regulator_hot_a_input};

    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            pin_level_next[i] = (sync2_reg[i] == sync3_reg[i]) ? sync3_reg[i] : pin_level_reg[i];
        end
        event_raw = {core_volt_b_event, core_volt_a_event, pin_level_reg};
        event_next[EMZO_REGULATOR_HOT_A] = event_raw[EMZO_REGULATOR_HOT_A] & ~misc_error_mask_reg[EMZO_REGULATOR_HOT_A];
        event_next[EMZO_REGULATOR_HOT_B] = event_raw[EMZO_REGULATOR_HOT_B] & ~misc_error_mask_reg[EMZO_REGULATOR_HOT_B];
        event_next[EMZO_TERM_SENSE_A]    = event_raw[EMZO_TERM_SENSE_A] & ~misc_error_mask_reg[EMZO_TERM_SENSE_A];
        event_next[EMZO_TERM_SENSE_B]    = event_raw[EMZO_TERM_SENSE_B] & ~misc_error_mask_reg[EMZO_TERM_SENSE_B];
        event_next[EMZO_CORE_VOLT_A]     = event_raw[EMZO_CORE_VOLT_A] & ~misc_error_mask_reg[EMZO_CORE_VOLT_A];
        event_next[EMZO_CORE_VOLT_B]     = event_raw[EMZO_CORE_VOLT_B] & ~misc_error_mask_reg[EMZO_CORE_VOLT_B];
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            sync1_reg     <= 4'h0;
            sync2_reg     <= 4'h0;
            sync3_reg     <= 4'h0;
            pin_level_reg <= 4'h0;
            event_reg     <= 6'h00;
        end
        else
        begin
            sync1_reg     <= pin_raw;
            sync2_reg     <= sync1_reg;
            sync3_reg     <= sync2_reg;
            pin_level_reg <= pin_level_next;
            event_reg     <= event_next;
        end
    end

    assign error_event = event_reg;

    // ------------------------------------------------------------------
    // Zone offset correction
    // ------------------------------------------------------------------
    emzo_offset_if #(.TEMP_WIDTH(TEMP_WIDTH)) zone1_if ();
    emzo_offset_if #(.TEMP_WIDTH(TEMP_WIDTH)) zone2_if ();

    assign zone1_if.raw_valid = zone1_raw_valid;
    assign zone1_if.raw_temp  = zone1_raw_temp;
    assign zone1_if.offset    = zone1_offset_field_reg;
    assign zone2_if.raw_valid = zone2_raw_valid;
    assign zone2_if.raw_temp  = zone2_raw_temp;
    assign zone2_if.offset    = zone2_offset_field_reg;

    emzo_offset_adder #(.TEMP_WIDTH(TEMP_WIDTH)) u_zone1_adder
    (
        .clock (clock),
        .rst   (rst),
        .zone  (zone1_if.adder)
    );

    emzo_offset_adder #(.TEMP_WIDTH(TEMP_WIDTH)) u_zone2_adder
    (
        .clock (clock),
        .rst   (rst),
        .zone  (zone2_if.adder)
    );

    // Downstream limit checks and fan logic see only the corrected value.
    assign zone1_temp_valid = zone1_if.corr_valid;
    assign zone1_temp       = zone1_if.corr_temp;
    assign zone2_temp_valid = zone2_if.corr_valid;
    assign zone2_temp       = zone2_if.corr_temp;

endmodule

// *** verif/emzo_bank_props.sv ***
// Checker for the error mask and zone offset bank.
// Sees only the bank's ports; bound by the statement at its foot.
`timescale 1ns/1ps
module emzo_bank_props
    import emzo_pkg::*;
#(
    parameter int TEMP_WIDTH = 8
)(
    input wire logic                  clock,
    input wire logic                  rst,
    input wire logic [7:0]            reg_addr,
    input wire logic                  reg_write,
    input wire logic [7:0]            reg_wdata,
    input wire logic [7:0]            reg_rdata,
    input wire logic                  core_volt_a_event,
    input wire logic                  core_volt_b_event,
    input wire logic [5:0]            error_event,
    input wire logic                  zone1_raw_valid,
    input wire logic [TEMP_WIDTH-1:0] zone1_raw_temp,
    input wire logic                  zone2_raw_valid,
    input wire logic [TEMP_WIDTH-1:0] zone2_raw_temp,
    input wire logic                  zone1_temp_valid,
    input wire logic [TEMP_WIDTH-1:0] zone1_temp,
    input wire logic                  zone2_temp_valid,
    input wire logic [TEMP_WIDTH-1:0] zone2_temp
);
    logic [5:0] mask_sh;
    logic [5:0] off1_sh;
    logic [5:0] off2_sh;
    logic [5:0] rd_exp;
    logic [7:0] addr_q;

    always_ff @(posedge clock)
    begin
        addr_q <= reg_addr;
        if (rst)
        begin
            mask_sh <= EMZO_MISC_ERROR_MASK_RESET;
            off1_sh <= EMZO_ZONE_OFFSET_RESET;
            off2_sh <= EMZO_ZONE_OFFSET_RESET;
        end
        else if (reg_write)
        begin
            if (reg_addr == EMZO_MISC_ERROR_MASK_ADDR) mask_sh <= reg_wdata[5:0];
            if (reg_addr == EMZO_ZONE1_TEMP_OFFSET_ADDR) off1_sh <= reg_wdata[5:0];
            if (reg_addr == EMZO_ZONE2_TEMP_OFFSET_ADDR) off2_sh <= reg_wdata[5:0];
        end
    end

    always_comb
        rd_exp = (addr_q == EMZO_MISC_ERROR_MASK_ADDR) ? mask_sh :
                 (addr_q == EMZO_ZONE1_TEMP_OFFSET_ADDR) ? off1_sh :
                 (addr_q == EMZO_ZONE2_TEMP_OFFSET_ADDR) ? off2_sh : 6'h00;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_hot_a; error_event[0] |-> !$past(mask_sh[0]); endproperty
    a_hot_a: assert property (p_hot_a) else $error("hot a event while masked");
    property p_hot_b; error_event[1] |-> !$past(mask_sh[1]); endproperty
    a_hot_b: assert property (p_hot_b) else $error("hot b event while masked");
    property p_term; !(|(error_event[3:2] & $past(mask_sh[3:2]))); endproperty
    a_term: assert property (p_term) else $error("term event while masked");
    property p_core;
        !$past(rst) |-> error_event[5:4] == $past({core_volt_b_event, core_volt_a_event} & ~mask_sh[5:4]);
    endproperty
    a_core: assert property (p_core) else $error("core event mismatch");
    property p_rd; !$past(rst) |-> reg_rdata == {2'b00, rd_exp}; endproperty
    a_rd: assert property (p_rd) else $error("read data mismatch");
    property p_z1;
        zone1_temp_valid |-> zone1_temp == $past(zone1_raw_temp) + TEMP_WIDTH'($signed($past(off1_sh)));
    endproperty
    a_z1: assert property (p_z1) else $error("zone 1 temp mismatch");
    property p_z2;
        zone2_temp_valid |-> zone2_temp == $past(zone2_raw_temp) + TEMP_WIDTH'($signed($past(off2_sh)));
    endproperty
    a_z2: assert property (p_z2) else $error("zone 2 temp mismatch");
    property p_hold; zone2_raw_valid ##1 !zone2_raw_valid |=> $stable(zone2_temp); endproperty
    a_hold: assert property (p_hold) else $error("zone 2 temp not held");

    c_neg: cover property (zone2_temp_valid && zone2_temp[7]);
    c_all: cover property (error_event == 6'h3F);
    c_mask: cover property (reg_write && reg_addr == EMZO_MISC_ERROR_MASK_ADDR);
endmodule

bind emzo_bank emzo_bank_props #(.TEMP_WIDTH(TEMP_WIDTH)) u_props (.*);

// *** verif/emzo_host.sv ***
// Host side of the register port: byte writes and address selection.
// Assumes the bank samples on the rising edge; drives on the falling edge.
`timescale 1ns/1ps
module emzo_host (
    input  wire logic       clock,
    output logic      [7:0] reg_addr,
    output logic            reg_write,
    output logic      [7:0] reg_wdata
);
    initial
    begin
        reg_addr = 8'h00;
        reg_write = 1'b0;
        reg_wdata = 8'h00;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
    begin
        @(negedge clock);
        reg_addr = a;
        reg_write = 1'b1;
        reg_wdata = d;
        @(negedge clock);
        reg_write = 1'b0;
        reg_wdata = ~d;
    end
    endtask

    task automatic point(input logic [7:0] a);
    begin
        @(negedge clock);
        reg_addr = a;
        @(negedge clock);
    end
    endtask
endmodule

// *** verif/error_mask_and_zone_offset_tb.sv ***
// Self-checking bench for the error mask and zone offset bank.
// Assumes the host model drives the register port.
`timescale 1ns/1ps
`define CHK(n, e, g) samples_checked++; if ((g) !== (e)) begin bad_count++; $display("wrong value %s expected %h seen %h", n, e, g); end
module error_mask_and_zone_offset_tb;
    import emzo_pkg::*;
    typedef struct {logic [7:0] addr; logic [7:0] off; logic [7:0] raw; logic [7:0] exp;} emzo_row_s;
    logic       clock, rst, z1v, z2v, z1tv, z2tv, reg_write;
    logic [3:0] pins;
    logic [1:0] core;
    logic [5:0] error_event;
    logic [7:0] z1raw, z2raw, z1t, z2t, reg_addr, reg_wdata, reg_rdata;
    int         bad_count = 0;
    int         samples_checked = 0;
    int         cycles = 0;
    emzo_row_s  rows [5] = '{'{8'hEF, 8'h3F, 8'h19, 8'h18}, '{8'hEF, 8'h1F, 8'h7F, 8'h9E},
        '{8'hEF, 8'h20, 8'h10, 8'hF0}, '{8'hEE, 8'h05, 8'hFD, 8'h02}, '{8'hEE, 8'h20, 8'h00, 8'hE0}};

    emzo_host u_host (.clock(clock), .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata));
    emzo_bank #(.TEMP_WIDTH(8)) u_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_write(reg_write),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .regulator_hot_a_input(pins[0]),
        .regulator_hot_b_input(pins[1]), .term_sense_a_input(pins[2]), .term_sense_b_input(pins[3]),
        .core_volt_a_event(core[0]), .core_volt_b_event(core[1]), .error_event(error_event),
        .zone1_raw_valid(z1v), .zone1_raw_temp(z1raw), .zone2_raw_valid(z2v), .zone2_raw_temp(z2raw),
        .zone1_temp_valid(z1tv), .zone1_temp(z1t), .zone2_temp_valid(z2tv), .zone2_temp(z2t));

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic test_done;
    begin
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            bad_count++;
            test_done;
        end
    end

    task automatic sample(input logic z1, input logic [7:0] raw);
    begin
        @(negedge clock);
        z1v = z1;
        z2v = !z1;
        z1raw = raw;
        z2raw = raw;
        @(negedge clock);
        z1v = 1'b0;
        z2v = 1'b0;
        z1raw = ~raw;
        z2raw = ~raw;
        `CHK("temp valid", 1'b1, z1 ? z1tv : z2tv)
    end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    begin
        u_host.point(a);
        `CHK("register read", e, reg_rdata)
    end
    endtask

    initial
    begin
        {rst, pins, core, z1v, z2v, z1raw, z2raw} = {1'b1, 24'h0};
        repeat (4) @(negedge clock);
        rst = 1'b0;
        rd_chk(EMZO_MISC_ERROR_MASK_ADDR, 8'h3F);
        rd_chk(EMZO_ZONE1_TEMP_OFFSET_ADDR, 8'h00);
        rd_chk(EMZO_ZONE2_TEMP_OFFSET_ADDR, 8'h00);
        rd_chk(8'hEC, 8'h00);
        foreach (rows[i])
        begin
            u_host.wr(rows[i].addr, rows[i].off);
            rd_chk(rows[i].addr, rows[i].off);
            sample(rows[i].addr == EMZO_ZONE1_TEMP_OFFSET_ADDR, rows[i].raw);
            `CHK("zone temp", rows[i].exp, rows[i].addr[0] ? z2t : z1t)
        end
        u_host.wr(EMZO_MISC_ERROR_MASK_ADDR, 8'hFF);
        rd_chk(EMZO_MISC_ERROR_MASK_ADDR, 8'h3F);
        pins = 4'hF;
        core = 2'b11;
        repeat (8) @(negedge clock);
        `CHK("events masked", 6'h00, error_event)
        u_host.wr(EMZO_MISC_ERROR_MASK_ADDR, 8'h15);
        repeat (2) @(negedge clock);
        `CHK("events half", 6'h2A, error_event)
        u_host.wr(EMZO_MISC_ERROR_MASK_ADDR, 8'h2A);
        repeat (2) @(negedge clock);
        `CHK("events other half", 6'h15, error_event)
        u_host.wr(EMZO_MISC_ERROR_MASK_ADDR, 8'h00);
        repeat (2) @(negedge clock);
        `CHK("events unmasked", 6'h3F, error_event)
        pins = 4'h0;
        repeat (8) @(negedge clock);
        `CHK("events cleared", 6'h30, error_event)
        // A pin high for a single cycle must not reach the event outputs.
        pins = 4'hF;
        @(negedge clock);
        pins = 4'h0;
        repeat (8) @(negedge clock);
        `CHK("pin glitch", 6'h30, error_event)
        rst = 1'b1;
        @(negedge clock);
        rst = 1'b0;
        `CHK("events after reset", 6'h00, error_event)
        rd_chk(EMZO_MISC_ERROR_MASK_ADDR, 8'h3F);
        // A write to an unmapped address must leave the mask untouched.
        u_host.wr(8'hEC, 8'h00);
        rd_chk(EMZO_MISC_ERROR_MASK_ADDR, 8'h3F);
        test_done;
    end
endmodule
